// ===== fep_pkg.sv
// Constants, codes and carrier types of the Fast Ethernet coding path
package fep_pkg;

    // ------------------------------------------------------------
    // Register map (index = printed register number)
    // ------------------------------------------------------------
    localparam logic [4:0] FEP_REG_CTRL = 5'h10;
    localparam logic [4:0] FEP_REG_STAT = 5'h11;
    localparam logic [4:0] FEP_REG_ADDR = 5'h12;

    localparam int FEP_CTRL_SYM_BIT = 0;
    localparam int FEP_CTRL_FDX_BIT = 1;
    localparam int FEP_CTRL_INV_BIT = 2;

    localparam int FEP_STAT_RECV_BIT = 3;
    localparam int FEP_STAT_LOCK_BIT = 4;
    localparam int FEP_STAT_PREM_BIT = 5;
    localparam int FEP_STAT_HALT_BIT = 6;
    localparam int FEP_STAT_INV_BIT = 7;

    localparam logic [2:0] FEP_CTRL_RESET = 3'h0;
    localparam logic [4:0] FEP_ADDR_RESET = 5'h00;
    localparam logic [2:0] FEP_STICKY_RESET = 3'h0;

    // ------------------------------------------------------------
    // Code groups
    // ------------------------------------------------------------
    localparam logic [4:0] FEP_SYM_I = 5'h1F;
    localparam logic [4:0] FEP_SYM_J = 5'h18;
    localparam logic [4:0] FEP_SYM_K = 5'h11;
    localparam logic [4:0] FEP_SYM_T = 5'h0D;
    localparam logic [4:0] FEP_SYM_R = 5'h07;
    localparam logic [4:0] FEP_SYM_H = 5'h04;
    localparam logic [4:0] FEP_SYM_BAD = 5'h00;
    localparam logic [3:0] FEP_PREAMBLE_NIB = 4'h5;

    // ------------------------------------------------------------
    // Counts (one clock = one code bit)
    // ------------------------------------------------------------
    localparam logic [2:0] FEP_SYM_LAST = 3'h4;
    localparam logic [2:0] FEP_CONFIRM_BITS = 3'h7;
    localparam logic [3:0] FEP_LOCK_BITS = 4'hB;
    localparam logic [10:0] FEP_CIPHER_RESET = 11'h7FF;
    localparam logic [4:0] FEP_SEED_FILL = 5'h1F;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FEP_TX_IDLE = 3'b000,
        FEP_TX_J = 3'b001,
        FEP_TX_K = 3'b010,
        FEP_TX_DATA = 3'b011,
        FEP_TX_T = 3'b100,
        FEP_TX_R = 3'b101
    } fep_tx_st_t;

    typedef enum logic [2:0] {
        FEP_RX_IDLE = 3'b000,
        FEP_RX_EXAM = 3'b001,
        FEP_RX_CARRIER = 3'b010,
        FEP_RX_RECV = 3'b011,
        FEP_RX_END = 3'b100
    } fep_rx_st_t;

    typedef struct packed {
        logic invalid_test;
        logic full_duplex;
        logic symbol_mode;
    } fep_ctrl_t;

    typedef struct packed {
        logic is_data;
        logic is_ctrl;
        logic [3:0] nib;
    } fep_dec_t;

    typedef struct packed {
        logic [1:0] level;
    } fep_line_t;

endpackage

// ===== fep_coding_path.sv
// 100Base-X coding path: 4B/5B, cipher, MLT-3 and carrier sense
`timescale 1ns/10ps

// Behaviour
// - In idle stream, a zero bit starts examination of following bits.
// - Second zero found enters carrier state and sets the receiving flag.
// - Receiving flag true drives carrier sense on.
// - Unconfirmed idle/J/K after carrier raises receive error and returns to idle.
// - Entering receive idle clears receiving, dropping carrier sense.
// - Confirmed idle, J, K moves to receive and delivers nibbles.
// - Each transmit nibble maps to one code group; data groups decode back.
// - Sixteen data groups, six control groups, ten invalid groups.
// - J,K start a frame, T,R end it, halt marks transmit error.
// - Undefined received group sets invalid-symbol status bit 17.7.
// - Received halt sets halt-detected status bit 17.6.
// - Invalid groups sent only with test bit 16.2 and transmit error input.
// - Transmit cipher register seeded from configured station address.
// - Symbol mode bypasses both scrambler and descrambler.
// - Descrambler restores received bit stream before framing.
// - Transmit bit stream becomes three-level MLT-3 line code.
// - Received MLT-3 levels convert back to a bit stream.
// - Half duplex asserts collision on simultaneous transmit and receive.
// - First two preamble nibbles sent as J,K; T,R appended at end.
// - Idles before end delimiter raise error, set 17.5, return idle.
module fep_coding_path (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [3:0] txd,
    input wire logic tx_en,
    input wire logic transmit_error_input,
    output logic tx_nib_stb,
    input wire logic pair_receive_plus,
    input wire logic line_rx_minus,
    output logic pair_transmit_plus,
    output logic line_tx_minus,
    output logic [3:0] rxd,
    output logic rx_nib_stb,
    output logic rx_er,
    output logic crs,
    output logic col
);
    import fep_pkg::*;

    // ------------------------------------------------------------
    // Code table
    // ------------------------------------------------------------
    function automatic logic [4:0] enc5(input logic [3:0] n);
        logic [4:0] c;
        c = 5'h00;
        case (n)
            4'h0: c = 5'h1E;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0A;
            4'h5: c = 5'h0B;
            4'h6: c = 5'h0E;
            4'h7: c = 5'h0F;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'hA: c = 5'h16;
            4'hB: c = 5'h17;
            4'hC: c = 5'h1A;
            4'hD: c = 5'h1B;
            4'hE: c = 5'h1C;
            default: c = 5'h1D;
        endcase
        return c;
    endfunction

    function automatic fep_dec_t dec5(input logic [4:0] s);
        fep_dec_t d;
        int i;
        d = '0;
        for (i = 0; i < 16; i++) begin
            if (enc5(i[3:0]) == s) begin
                d.is_data = 1'b1;
                d.nib = i[3:0];
            end
        end
        d.is_ctrl = (s == FEP_SYM_I) || (s == FEP_SYM_J) || (s == FEP_SYM_K) ||
                    (s == FEP_SYM_T) || (s == FEP_SYM_R) || (s == FEP_SYM_H);
        return d;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    fep_ctrl_t ctrl_q;
    logic [4:0] addr_q;
    logic [2:0] sticky_q;
    logic [15:0] rdata_q;
    logic seed_pend_q;
    logic locked_q;
    logic [3:0] lock_cnt_q;
    fep_rx_st_t rx_st_q, rx_st_d;

    wire wr_ctrl = reg_wr && (reg_addr == FEP_REG_CTRL);
    wire wr_addr = reg_wr && (reg_addr == FEP_REG_ADDR);
    wire rd_stat = reg_rd && (reg_addr == FEP_REG_STAT);
    wire receiving = (rx_st_q == FEP_RX_CARRIER) || (rx_st_q == FEP_RX_RECV) || (rx_st_q == FEP_RX_END);
    // Carrier sense and collision share one view of the next receive state
    wire receiving_d = (rx_st_d == FEP_RX_CARRIER) || (rx_st_d == FEP_RX_RECV) || (rx_st_d == FEP_RX_END);
    logic [15:0] status_word;
    logic [15:0] rd_mux;
    logic [2:0] sticky_set;

    always_comb begin
        status_word = 16'h0000;
        status_word[FEP_STAT_INV_BIT] = sticky_q[2];
        status_word[FEP_STAT_HALT_BIT] = sticky_q[1];
        status_word[FEP_STAT_PREM_BIT] = sticky_q[0];
        status_word[FEP_STAT_LOCK_BIT] = locked_q;
        status_word[FEP_STAT_RECV_BIT] = receiving;
        if (reg_addr == FEP_REG_CTRL) begin
            rd_mux = {13'h0000, ctrl_q};
        end else if (reg_addr == FEP_REG_STAT) begin
            rd_mux = status_word;
        end else if (reg_addr == FEP_REG_ADDR) begin
            rd_mux = {11'h000, addr_q};
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // Latching bits clear on read; a set in the same cycle wins
    wire [2:0] sticky_d = (sticky_q & ~{3{rd_stat}}) | sticky_set;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= FEP_CTRL_RESET;
            addr_q <= FEP_ADDR_RESET;
            sticky_q <= FEP_STICKY_RESET;
            rdata_q <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata[2:0];
            end
            if (wr_addr) begin
                addr_q <= reg_wdata[4:0];
            end
            sticky_q <= sticky_d;
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Transmit: framing and 4B/5B
    // ------------------------------------------------------------
    fep_tx_st_t tx_st_q, tx_st_d;
    logic [2:0] tx_bit_q;
    logic [4:0] tx_sym_q;
    logic [4:0] tx_sym_d;
    wire sym_end = (tx_bit_q == FEP_SYM_LAST);
    wire tx_bad = transmit_error_input && ctrl_q.invalid_test;
    wire [4:0] tx_data_sym = transmit_error_input ? (tx_bad ? FEP_SYM_BAD : FEP_SYM_H) : enc5(txd);

    always_comb begin
        tx_st_d = tx_st_q;
        tx_sym_d = FEP_SYM_I;
        case (tx_st_q)
            FEP_TX_IDLE: begin
                if (tx_en) begin
                    tx_st_d = FEP_TX_J;
                    tx_sym_d = FEP_SYM_J;
                end
            end
            FEP_TX_J: begin
                tx_st_d = tx_en ? FEP_TX_K : FEP_TX_T;
                tx_sym_d = tx_en ? FEP_SYM_K : FEP_SYM_T;
            end
            FEP_TX_K, FEP_TX_DATA: begin
                tx_st_d = tx_en ? FEP_TX_DATA : FEP_TX_T;
                tx_sym_d = tx_en ? tx_data_sym : FEP_SYM_T;
            end
            FEP_TX_T: begin
                tx_st_d = FEP_TX_R;
                tx_sym_d = FEP_SYM_R;
            end
            default: begin
                tx_st_d = FEP_TX_IDLE;
                tx_sym_d = FEP_SYM_I;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_st_q <= FEP_TX_IDLE;
            tx_bit_q <= 3'h0;
            tx_sym_q <= FEP_SYM_I;
            tx_nib_stb <= 1'b0;
        end else begin
            tx_bit_q <= sym_end ? 3'h0 : tx_bit_q + 3'h1;
            tx_nib_stb <= sym_end;
            if (sym_end) begin
                tx_st_q <= tx_st_d;
                tx_sym_q <= tx_sym_d;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit: cipher, NRZI and MLT-3
    // ------------------------------------------------------------
    logic [10:0] scr_q;
    logic tx_nrzi_q;
    logic [1:0] mlt_ph_q;
    logic line_pos_q, line_neg_q;
    wire tx_code_bit = tx_sym_q[3'h4 - tx_bit_q];
    wire scr_ks = scr_q[10] ^ scr_q[8];
    wire tx_line_bit = ctrl_q.symbol_mode ? tx_code_bit : (tx_code_bit ^ scr_ks);
    wire tx_nrzi_d = tx_nrzi_q ^ tx_line_bit;
    // NRZI edge drives the MLT-3 step
    wire [1:0] mlt_ph_d = (tx_nrzi_d != tx_nrzi_q) ? mlt_ph_q + 2'h1 : mlt_ph_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scr_q <= FEP_CIPHER_RESET;
            seed_pend_q <= 1'b1;
            tx_nrzi_q <= 1'b0;
            mlt_ph_q <= 2'h0;
            line_pos_q <= 1'b0;
            line_neg_q <= 1'b0;
        end else begin
            seed_pend_q <= wr_addr;
            // Seed kept non-zero by the fill bits so the cipher cannot stall
            scr_q <= seed_pend_q ? {1'b1, addr_q, FEP_SEED_FILL} : {scr_q[9:0], scr_ks};
            tx_nrzi_q <= tx_nrzi_d;
            mlt_ph_q <= mlt_ph_d;
            line_pos_q <= (mlt_ph_d == 2'h1);
            line_neg_q <= (mlt_ph_d == 2'h3);
        end
    end
    assign pair_transmit_plus = line_pos_q;
    assign line_tx_minus = line_neg_q;

    // ------------------------------------------------------------
    // Receive: line decode and descrambler
    // ------------------------------------------------------------
    logic [1:0] rx_s1_q, rx_s2_q;
    fep_line_t rx_lvl_q;
    logic rx_nrzi_q, rx_nrzi_old_q;
    logic [10:0] dsc_q;
    wire [1:0] rx_lvl_now = rx_s2_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_s1_q <= 2'h0;
            rx_s2_q <= 2'h0;
            rx_lvl_q <= '0;
            rx_nrzi_q <= 1'b0;
            rx_nrzi_old_q <= 1'b0;
        end else begin
            rx_s1_q <= {pair_receive_plus, line_rx_minus};
            rx_s2_q <= rx_s1_q;
            rx_lvl_q.level <= rx_lvl_now;
            rx_nrzi_q <= rx_nrzi_q ^ (rx_lvl_now != rx_lvl_q.level);
            rx_nrzi_old_q <= rx_nrzi_q;
        end
    end

    wire rx_code_bit = rx_nrzi_q ^ rx_nrzi_old_q;
    wire dsc_ks = dsc_q[10] ^ dsc_q[8];
    wire rx_plain = ctrl_q.symbol_mode ? rx_code_bit : (rx_code_bit ^ dsc_ks);
    wire bit_ok = ctrl_q.symbol_mode || locked_q;
    logic false_carrier;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dsc_q <= FEP_CIPHER_RESET;
            locked_q <= 1'b0;
            lock_cnt_q <= 4'h0;
        end else begin
            // Learned from idle ones while unlocked, free-running once locked
            dsc_q <= locked_q ? {dsc_q[9:0], dsc_ks} : {dsc_q[9:0], ~rx_code_bit};
            if (false_carrier) begin
                locked_q <= 1'b0;
                lock_cnt_q <= 4'h0;
            end else if (!locked_q) begin
                lock_cnt_q <= lock_cnt_q + 4'h1;
                locked_q <= (lock_cnt_q + 4'h1 == FEP_LOCK_BITS);
            end
        end
    end

    // ------------------------------------------------------------
    // Receive: carrier detect, framing and decode
    // ------------------------------------------------------------
    logic [19:0] hist_q;
    logic [2:0] cnt_q, cnt_d;
    logic pre_pend_q, pre_pend_d;
    logic nib_out, err_out;
    logic [3:0] nib_val;
    wire [2:0] cnt_nx = cnt_q + 3'h1;
    wire [19:0] hist_nx = {hist_q[18:0], rx_plain};
    wire [4:0] rx_sym = hist_nx[4:0];
    fep_dec_t rx_dec;
    assign rx_dec = dec5(rx_sym);

    always_comb begin
        rx_st_d = rx_st_q;
        cnt_d = cnt_q;
        pre_pend_d = 1'b0;
        nib_out = 1'b0;
        nib_val = rx_dec.nib;
        err_out = 1'b0;
        sticky_set = 3'h0;
        false_carrier = 1'b0;
        if (pre_pend_q) begin
            nib_out = 1'b1;
            nib_val = FEP_PREAMBLE_NIB;
        end
        if (bit_ok) begin
            case (rx_st_q)
                FEP_RX_IDLE: begin
                    if (!rx_plain) begin
                        rx_st_d = FEP_RX_EXAM;
                        cnt_d = 3'h0;
                    end
                end
                FEP_RX_EXAM: begin
                    cnt_d = cnt_nx;
                    if (!rx_plain) begin
                        rx_st_d = FEP_RX_CARRIER;
                    end else if (cnt_nx == FEP_CONFIRM_BITS) begin
                        rx_st_d = FEP_RX_IDLE;
                    end
                end
                FEP_RX_CARRIER: begin
                    cnt_d = cnt_nx;
                    if (cnt_nx == FEP_CONFIRM_BITS) begin
                        if (hist_nx[14:0] == {FEP_SYM_I, FEP_SYM_J, FEP_SYM_K}) begin
                            rx_st_d = FEP_RX_RECV;
                            cnt_d = 3'h0;
                            nib_out = 1'b1;
                            nib_val = FEP_PREAMBLE_NIB;
                            pre_pend_d = 1'b1;
                        end else begin
                            rx_st_d = FEP_RX_IDLE;
                            err_out = 1'b1;
                            false_carrier = !ctrl_q.symbol_mode;
                        end
                    end
                end
                FEP_RX_RECV: begin
                    cnt_d = (cnt_q == FEP_SYM_LAST) ? 3'h0 : cnt_nx;
                    if (cnt_q == FEP_SYM_LAST) begin
                        if (rx_dec.is_data) begin
                            nib_out = 1'b1;
                        end else if (rx_sym == FEP_SYM_T) begin
                            rx_st_d = FEP_RX_END;
                        end else if (rx_sym == FEP_SYM_I) begin
                            rx_st_d = FEP_RX_IDLE;
                            err_out = 1'b1;
                            sticky_set[0] = 1'b1;
                        end else begin
                            err_out = 1'b1;
                            sticky_set[1] = (rx_sym == FEP_SYM_H);
                            sticky_set[2] = !rx_dec.is_ctrl;
                        end
                    end
                end
                default: begin
                    cnt_d = (cnt_q == FEP_SYM_LAST) ? 3'h0 : cnt_nx;
                    if (cnt_q == FEP_SYM_LAST) begin
                        rx_st_d = FEP_RX_IDLE;
                        err_out = (rx_sym != FEP_SYM_R);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_st_q <= FEP_RX_IDLE;
            hist_q <= 20'hFFFFF;
            cnt_q <= 3'h0;
            pre_pend_q <= 1'b0;
            rxd <= 4'h0;
            rx_nib_stb <= 1'b0;
            rx_er <= 1'b0;
            crs <= 1'b0;
            col <= 1'b0;
        end else begin
            if (bit_ok) begin
                hist_q <= hist_nx;
            end
            rx_st_q <= rx_st_d;
            cnt_q <= cnt_d;
            pre_pend_q <= pre_pend_d;
            rxd <= nib_out ? nib_val : rxd;
            rx_nib_stb <= nib_out;
            rx_er <= err_out;
            crs <= receiving_d;
            col <= !ctrl_q.full_duplex && (tx_st_q != FEP_TX_IDLE) && receiving_d;
        end
    end

endmodule

// ===== fep_coding_path_checker.sv
// Port-level assertions for the Fast Ethernet coding path
`timescale 1ns/10ps
// ----------
// Checker
// ----------
module fep_coding_path_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic tx_nib_stb,
    input wire logic pair_transmit_plus,
    input wire logic line_tx_minus,
    input wire logic [3:0] rxd,
    input wire logic rx_nib_stb,
    input wire logic rx_er,
    input wire logic crs,
    input wire logic col
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // First event after carrier: a nibble or a receive error
    sequence first_evt;
        $rose(crs) ##[1:20] (rx_nib_stb || rx_er);
    endsequence
    sequence pre_pair;
        rx_nib_stb && rxd == 4'h5 ##1 rx_nib_stb && rxd == 4'h5;
    endsequence

    line_excl_a: assert property (!(pair_transmit_plus && line_tx_minus))
        else $error("both line levels driven");
    mlt_up_a: assert property ($past(pair_transmit_plus) |-> !line_tx_minus)
        else $error("line jumped from plus to minus");
    mlt_down_a: assert property ($past(line_tx_minus) |-> !pair_transmit_plus)
        else $error("line jumped from minus to plus");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its slot");
    nib_pace_a: assert property (tx_nib_stb |=> !tx_nib_stb [*4] ##1 tx_nib_stb)
        else $error("transmit nibble pace is not five cycles");
    rxer_pulse_a: assert property (rx_er |=> !rx_er)
        else $error("receive error longer than one cycle");
    nib_carrier_a: assert property (rx_nib_stb |-> crs)
        else $error("nibble delivered without carrier");
    col_recv_a: assert property (col |-> crs)
        else $error("collision without reception");
    ssd_bound_a: assert property ($rose(crs) |-> ##[1:20] (rx_nib_stb || rx_er))
        else $error("carrier neither confirmed nor refused");
    pre_pair_a: assert property (first_match(first_evt) |-> rx_er or pre_pair)
        else $error("start delimiter not delivered as two preamble nibbles");
endmodule

// ===== fep_medium.sv
// Twisted-pair medium model: loopback or a commanded bit source
`timescale 1ns/10ps
module fep_medium (
    input wire logic clk,
    input wire logic loop,
    input wire logic bit_in,
    input wire logic tx_plus,
    input wire logic tx_minus,
    output logic rx_plus = 1'b0,
    output logic rx_minus = 1'b0
);
    logic last_pos = 1'b0;

    // Own source continues from the looped level, so a switch adds no false step
    always @(posedge clk) begin
        if (loop) begin
            rx_plus <= tx_plus;
            rx_minus <= tx_minus;
            if (tx_plus || tx_minus) last_pos <= tx_plus;
        end else if (bit_in && (rx_plus || rx_minus)) begin
            rx_plus <= 1'b0;
            rx_minus <= 1'b0;
        end else if (bit_in) begin
            rx_plus <= !last_pos;
            rx_minus <= last_pos;
            last_pos <= !last_pos;
        end
    end
endmodule

// ===== fep_coding_path_tb.sv
// Self-checking bench for the Fast Ethernet coding path
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module fep_coding_path_tb;
    import fep_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] txd = 4'h0;
    logic tx_en = 1'b0;
    logic txe = 1'b0;
    logic loop = 1'b1;
    logic bit_in = 1'b1;
    logic [15:0] reg_rdata, d;
    logic tx_nib_stb, rxp, rxm, txp, txm, rx_nib_stb, rx_er, crs, col;
    logic [3:0] rxd;
    logic saw_col = 1'b0;
    logic saw_crs = 1'b0;
    logic saw_er = 1'b0;
    logic [3:0] got[$];
    logic [31:0] s1, s2, s3;
    logic [15:0] modes[4] = '{16'h0002, 16'h0000, 16'h0001, 16'h0004};
    int num_errors = 0;
    int n_tests = 0;

    always #50 clk = ~clk;

    fep_coding_path u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd), .tx_en(tx_en),
        .transmit_error_input(txe), .tx_nib_stb(tx_nib_stb), .pair_receive_plus(rxp), .line_rx_minus(rxm),
        .pair_transmit_plus(txp), .line_tx_minus(txm), .rxd(rxd), .rx_nib_stb(rx_nib_stb),
        .rx_er(rx_er), .crs(crs), .col(col));
    fep_medium u_med (.clk(clk), .loop(loop), .bit_in(bit_in), .tx_plus(txp), .tx_minus(txm),
        .rx_plus(rxp), .rx_minus(rxm));

    // ----------
    // Receive monitor
    // ----------
    always @(posedge clk) begin
        if (rx_nib_stb === 1'b1) got.push_back(rxd);
        saw_col |= (col === 1'b1);
        saw_crs |= (crs === 1'b1);
        saw_er |= (rx_er === 1'b1);
    end

    // ----------
    // Access tasks
    // ----------
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Old strobe value at the edge means the next sample is four edges away
    task automatic nib(input logic [3:0] n, input logic en, input logic er);
        int k;
        k = 0;
        @(posedge clk);
        while (tx_nib_stb !== 1'b1 && k < 10) begin
            @(posedge clk);
            k++;
        end
        txd <= n;
        tx_en <= en;
        txe <= er;
    endtask
    task automatic frame(input int n, input int err_at);
        for (int i = 0; i < n + 2; i++) nib((i < 2) ? 4'h5 : 4'(i - 2), 1'b1, i == err_at);
        for (int i = 0; i < 4; i++) nib(4'h0, 1'b0, 1'b0);
    endtask
    task automatic clr;
        rd(FEP_REG_STAT, d);
        @(negedge clk);
        got.delete();
        saw_col = 1'b0;
        saw_crs = 1'b0;
        saw_er = 1'b0;
    endtask
    task automatic bits(input logic [15:0] p);
        loop <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk);
            bit_in <= p[i];
        end
        @(posedge clk);
        bit_in <= 1'b1;
        repeat (40) @(posedge clk);
    endtask
    // Line transitions equal the coded ones, whatever the level phase
    task automatic sig(output logic [31:0] s);
        logic [1:0] p;
        repeat (6) @(posedge clk);
        p = {txp, txm};
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            s = {s[30:0], {txp, txm} != p};
            p = {txp, txm};
        end
    endtask
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ----------
    // Tests
    // ----------
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (20) @(posedge clk);
        rd(FEP_REG_CTRL, d);
        `CHK(d, 16'h0000)
        rd(FEP_REG_ADDR, d);
        `CHK(d, 16'h0000)
        rd(FEP_REG_STAT, d);
        `CHK(d[7:5], 3'h0)
        wr(5'h00, 16'hFFFF);
        rd(5'h00, d);
        `CHK(d, 16'h0000)
        wr(FEP_REG_ADDR, 16'hFFFF);
        rd(FEP_REG_ADDR, d);
        `CHK(d, 16'h001F)
        wr(FEP_REG_CTRL, 16'hFFF8);
        rd(FEP_REG_CTRL, d);
        `CHK(d, 16'h0000)
        done("registers");
        // Settle time lets the descrambler relock after a seed or mode change
        for (int m = 0; m < 4; m++) begin
            wr(FEP_REG_CTRL, modes[m]);
            repeat (100) @(posedge clk);
            clr();
            frame(16, -1);
            repeat (40) @(posedge clk);
            `CHK(got.size(), 18)
            foreach (got[i]) `CHK(got[i], (i < 2) ? 4'h5 : 4'(i - 2))
            `CHK(saw_col, ~modes[m][1])
            `CHK(saw_crs, 1'b1)
            `CHK(saw_er | crs, 1'b0)
            done("frame");
        end
        for (int m = 0; m < 2; m++) begin
            wr(FEP_REG_CTRL, m ? 16'h0004 : 16'h0000);
            clr();
            frame(4, 3);
            repeat (40) @(posedge clk);
            rd(FEP_REG_STAT, d);
            `CHK(d[7:5], m ? 3'h4 : 3'h2)
            `CHK(saw_er, 1'b1)
            done("error symbol");
        end
        wr(FEP_REG_CTRL, 16'h0001);
        // Scrambled bits still in the receive pipe would fake a carrier
        repeat (40) @(posedge clk);
        clr();
        bits(16'hBFFF);
        `CHK(saw_crs, 1'b0)
        bits(16'hAFFF);
        `CHK({saw_crs, saw_er, crs}, 3'b110)
        `CHK(got.size(), 0)
        loop <= 1'b1;
        done("false carrier");
        clr();
        fork
            frame(16, -1);
            begin
                wait (got.size() >= 6);
                loop <= 1'b0;
            end
        join
        repeat (40) @(posedge clk);
        loop <= 1'b1;
        rd(FEP_REG_STAT, d);
        `CHK({d[5], saw_er, crs}, 3'b110)
        done("premature end");
        wr(FEP_REG_CTRL, 16'h0000);
        wr(FEP_REG_ADDR, 16'h0015);
        sig(s1);
        wr(FEP_REG_ADDR, 16'h0015);
        sig(s2);
        wr(FEP_REG_ADDR, 16'h000A);
        sig(s3);
        `CHK(s1, s2)
        `CHK(s1 != s3, 1'b1)
        `CHK(s1 != 32'hFFFFFFFF, 1'b1)
        wr(FEP_REG_CTRL, 16'h0001);
        sig(s1);
        `CHK(s1, 32'hFFFFFFFF)
        done("line coding");
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("watchdog expired at %0t", $time);
        complete_run();
    end
endmodule

bind fep_coding_path fep_coding_path_checker u_chk (.clk(clk), .reset_n(reset_n), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_nib_stb(tx_nib_stb), .pair_transmit_plus(pair_transmit_plus),
    .line_tx_minus(line_tx_minus), .rxd(rxd), .rx_nib_stb(rx_nib_stb), .rx_er(rx_er), .crs(crs), .col(col));
